/* File: rtl/lbd_led_boost.sv */
// White LED boost converter digital control: dimming and PFM switch control
// Function
// - Duty one half: every pulse half on
// - Adjust duty with fully on or off pulses
// - Rate bit: high 183 Hz, low 122 Hz
// - Exactly 256 pulse slots per period
// - Switch on when feedback low, LED on
// - Switch off at current limit or 6 us
// - LED switch off forces power switch off
// - Shutdown holds LED switch open
// - LED pattern follows host duty setting
// - Soft-start limit 125, 250, 500 mA
// - First two steps last 256 switching cycles each
// - Zero duty is off, nonzero enables converter
// - Lockout or thermal shutdown opens both switches
`timescale 1ns/1ps
module lbd_led_boost (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Host settings, same clock domain
  input  wire logic [7:0] led_duty_setting_i,
  input  wire logic       rep_rate_select_i,
  // Analog comparators and protection, asynchronous
  input  wire logic       current_sense_input_low_i,
  input  wire logic       peak_limit_reached_i,
  input  wire logic       uvlo_i,
  input  wire logic       thermal_shutdown_i,
  // Switch drives and status
  output logic            led_switch_on_o,
  output logic            power_switch_on_o,
  output logic [1:0]      current_limit_sel_o,
  output logic            converter_enabled_o
);
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       pwr_on;
  logic [9:0] on_cnt;
  logic [8:0] sw_cnt;
  logic [1:0] limit_sel;
  logic       enabled;
  lbd_pkg::lbd_mode_e mode;
  lbd_pkg::lbd_mode_e next_mode;
  logic       led_on;

  // Two stages on every asynchronous comparator and protection flag
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= {thermal_shutdown_i, uvlo_i, peak_limit_reached_i, current_sense_input_low_i};
      sync_b <= sync_a;
    end
  end

  wire logic fb_low    = sync_b[0];
  wire logic peak_hit  = sync_b[1];
  wire logic fault     = sync_b[2] | sync_b[3];
  wire logic next_enabled = (led_duty_setting_i != lbd_pkg::DUTY_OFF) && !fault;

  lbd_dimming u_dimming (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .enable_i    (enabled),
    .duty_i      (led_duty_setting_i),
    .rate_fast_i (rep_rate_select_i),
    .led_on_o    (led_on)
  );

  wire logic on_timeout = (on_cnt >= lbd_pkg::MAX_ON_CYC - 10'h001);
  wire logic turn_off   = pwr_on && (peak_hit || on_timeout || !led_on || !enabled);
  wire logic turn_on    = !pwr_on && fb_low && led_on && enabled;
  wire logic step_done  = turn_on && (sw_cnt == lbd_pkg::SS_STEP_CYCLES - 9'h001);

  always_comb begin
    next_mode = mode;
    case (mode)
      lbd_pkg::LBD_OFF: next_mode = lbd_pkg::LBD_SS1;
      lbd_pkg::LBD_SS1: if (step_done) begin
        next_mode = lbd_pkg::LBD_SS2;
      end
      lbd_pkg::LBD_SS2: if (step_done) begin
        next_mode = lbd_pkg::LBD_RUN;
      end
      default: next_mode = lbd_pkg::LBD_RUN;
    endcase
    if (!enabled) begin
      next_mode = lbd_pkg::LBD_OFF;
    end
  end

  // Limit steps follow the soft-start phase
  wire logic [1:0] next_limit = (next_mode == lbd_pkg::LBD_RUN) ? lbd_pkg::LIMIT_500MA :
                                (next_mode == lbd_pkg::LBD_SS2) ? lbd_pkg::LIMIT_250MA :
                                lbd_pkg::LIMIT_125MA;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enabled   <= 1'b0;
      mode      <= lbd_pkg::LBD_OFF;
      limit_sel <= lbd_pkg::LIMIT_125MA;
    end else begin
      enabled   <= next_enabled;
      mode      <= next_mode;
      limit_sel <= next_limit;
    end
  end

  // Switching cycles count from each turn-on; reset at step boundaries
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_cnt <= 9'h000;
    end else if (!enabled || step_done) begin
      sw_cnt <= 9'h000;
    end else if (turn_on && mode != lbd_pkg::LBD_RUN) begin
      sw_cnt <= sw_cnt + 9'h001;
    end
  end

  // Off for at least one cycle after each turn-off, so DCM restarts cleanly
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_on <= 1'b0;
      on_cnt <= 10'h000;
    end else if (turn_off) begin
      pwr_on <= 1'b0;
      on_cnt <= 10'h000;
    end else if (turn_on) begin
      pwr_on <= 1'b1;
      on_cnt <= 10'h000;
    end else if (pwr_on) begin
      on_cnt <= on_cnt + 10'h001;
    end
  end

  assign led_switch_on_o     = led_on;
  assign power_switch_on_o   = pwr_on;
  assign current_limit_sel_o = limit_sel;
  assign converter_enabled_o = enabled;
endmodule

/* File: rtl/lbd_pkg.sv */
// Constants shared by the LED boost dimming control design
package lbd_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SLOTS         = 256;
  localparam int unsigned REP_FAST_HZ   = 183;
  localparam int unsigned REP_SLOW_HZ   = 122;
  localparam int unsigned SLOT_FAST_CYC = CLK_HZ / (REP_FAST_HZ * SLOTS);
  localparam int unsigned SLOT_SLOW_CYC = CLK_HZ / (REP_SLOW_HZ * SLOTS);
  localparam logic [11:0] SLOT_FAST_LEN = 12'(SLOT_FAST_CYC);
  localparam logic [11:0] SLOT_SLOW_LEN = 12'(SLOT_SLOW_CYC);
  localparam logic [7:0]  DUTY_HALF     = 8'h80;
  localparam logic [7:0]  DUTY_OFF      = 8'h00;
  localparam int unsigned MAX_ON_NS     = 6000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [9:0]  MAX_ON_CYC    = 10'(MAX_ON_NS / CLK_PERIOD_NS);
  localparam logic [8:0]  SS_STEP_CYCLES = 9'h100;
  localparam logic [1:0]  LIMIT_125MA   = 2'h0;
  localparam logic [1:0]  LIMIT_250MA   = 2'h1;
  localparam logic [1:0]  LIMIT_500MA   = 2'h2;
  typedef enum logic [1:0] {LBD_OFF, LBD_SS1, LBD_SS2, LBD_RUN} lbd_mode_e;
endpackage

/* File: rtl/lbd_dimming.sv */
// Burst dimming generator for the LED series switch
`timescale 1ns/1ps
module lbd_dimming (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       enable_i,
  input  wire logic [7:0] duty_i,
  input  wire logic       rate_fast_i,
  // LED switch
  output logic            led_on_o
);
  logic [11:0] cyc;
  logic [7:0]  slot;
  logic        led_on;

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  wire logic [11:0] slot_len = rate_fast_i ? lbd_pkg::SLOT_FAST_LEN : lbd_pkg::SLOT_SLOW_LEN;
  wire logic        slot_end = (cyc >= slot_len - 12'h001);
  wire logic        first_half = (cyc < {1'b0, slot_len[11:1]});
  wire logic        above_half = (duty_i >= lbd_pkg::DUTY_HALF);
  // Count of slots forced full on (above half) or full off (below half)
  wire logic [8:0]  forced = above_half ? {duty_i - lbd_pkg::DUTY_HALF, 1'b0}
                                        : 9'h100 - {duty_i, 1'b0};
  // Bit reversal spreads forced slots evenly over the period
  wire logic        slot_forced = ({1'b0, bit_rev(slot)} < forced);
  wire logic        next_led_on = enable_i && (slot_forced ? above_half : first_half);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc    <= 12'h000;
      slot   <= 8'h00;
      led_on <= 1'b0;
    end else if (!enable_i) begin
      cyc    <= 12'h000;
      slot   <= 8'h00;
      led_on <= 1'b0;
    end else begin
      cyc    <= slot_end ? 12'h000 : cyc + 12'h001;
      slot   <= slot_end ? slot + 8'h01 : slot;
      led_on <= next_led_on;
    end
  end

  assign led_on_o = led_on;
endmodule

/* File: tb/lbd_led_boost_chk.sv */
// Assertion checker for the LED boost dimming control
`timescale 1ns/1ps
module lbd_chk (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] led_duty_setting_i,
  input wire logic       uvlo_i,
  input wire logic       peak_limit_reached_i,
  input wire logic       led_switch_on_o,
  input wire logic       power_switch_on_o,
  input wire logic [1:0] current_limit_sel_o,
  input wire logic       converter_enabled_o
);
  logic [9:0] on_len;
  // Counter instead of a long repetition
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      on_len <= 10'h000;
    end else begin
      on_len <= power_switch_on_o ? on_len + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_led_off; !led_switch_on_o && power_switch_on_o |=> !power_switch_on_o; endproperty
  a_led_off: assert property (p_led_off) else $error("power on after led off");
  property p_on_cause; $rose(power_switch_on_o) |-> $past(led_switch_on_o) && $past(converter_enabled_o); endproperty
  a_on_cause: assert property (p_on_cause) else $error("power on without led on");
  property p_max_on; on_len <= 10'h258; endproperty
  a_max_on: assert property (p_max_on) else $error("on time too long");
  property p_peak; peak_limit_reached_i [*3] |=> !power_switch_on_o; endproperty
  a_peak: assert property (p_peak) else $error("power on past limit");
  property p_zero; led_duty_setting_i == 8'h00 |=> !converter_enabled_o; endproperty
  a_zero: assert property (p_zero) else $error("enabled at zero duty");
  property p_shut; !converter_enabled_o [*3] |-> !led_switch_on_o; endproperty
  a_shut: assert property (p_shut) else $error("led on while off");
  property p_dis_pwr; !converter_enabled_o [*2] |-> !power_switch_on_o; endproperty
  a_dis_pwr: assert property (p_dis_pwr) else $error("power on while off");
  property p_fault; uvlo_i [*6] |-> !converter_enabled_o && !power_switch_on_o && !led_switch_on_o; endproperty
  a_fault: assert property (p_fault) else $error("switch on in lockout");
  property p_limit; $changed(current_limit_sel_o) |-> current_limit_sel_o != 2'h3 &&
    (current_limit_sel_o == 2'h0 || current_limit_sel_o == $past(current_limit_sel_o) + 2'h1); endproperty
  a_limit: assert property (p_limit) else $error("bad limit step");
  c_ss_done: cover property (current_limit_sel_o == 2'h2);
  c_max_on: cover property (on_len == 10'h258);
  c_fault: cover property (uvlo_i && converter_enabled_o);
endmodule
bind lbd_led_boost lbd_chk i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .led_duty_setting_i(led_duty_setting_i),
  .uvlo_i(uvlo_i), .peak_limit_reached_i(peak_limit_reached_i), .led_switch_on_o(led_switch_on_o),
  .power_switch_on_o(power_switch_on_o), .current_limit_sel_o(current_limit_sel_o),
  .converter_enabled_o(converter_enabled_o));

/* File: tb/lbd_plant.sv */
// Inductor and LED string model feeding the comparators
`timescale 1ns/1ps
module lbd_plant (
  input  wire logic clk_i,
  input  wire logic power_on_i,
  input  wire logic slow_ramp_i,
  output logic      fb_low_o,
  output logic      peak_o
);
  int ramp = 0;
  always @(posedge clk_i) ramp <= power_on_i ? ramp + 1 : 0;
  // Slow ramp outlasts the maximum on-time
  assign peak_o   = power_on_i && ramp >= (slow_ramp_i ? 2000 : 4);
  assign fb_low_o = !power_on_i;
endmodule

/* File: tb/tb.sv */
// Self-checking testbench for the LED boost dimming control
`timescale 1ns/1ps
module tb;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [7:0] duty     = 8'h00;
  logic       rate     = 1'b1;
  logic       uvlo     = 1'b0;
  logic       hot      = 1'b0;
  logic       slow     = 1'b0;
  logic       fb_low, peak, led_on, pwr_on, enabled;
  logic [1:0] lim_sel;
  int         err_count = 0;
  int         compares  = 0;
  always #5 clk_i = ~clk_i;
  lbd_led_boost i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .led_duty_setting_i(duty), .rep_rate_select_i(rate),
    .current_sense_input_low_i(fb_low), .peak_limit_reached_i(peak), .uvlo_i(uvlo), .thermal_shutdown_i(hot),
    .led_switch_on_o(led_on), .power_switch_on_o(pwr_on), .current_limit_sel_o(lim_sel),
    .converter_enabled_o(enabled));
  lbd_plant i_plant (.clk_i(clk_i), .power_on_i(pwr_on), .slow_ramp_i(slow), .fb_low_o(fb_low), .peak_o(peak));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  // Zero duty first so the slot counters restart
  task automatic set_duty(input logic [7:0] d, input logic r);
    @(negedge clk_i);
    duty = 8'h00;
    repeat (4) @(negedge clk_i);
    rate = r;
    duty = d;
    @(posedge led_on);
  endtask
  task automatic t_dim(input logic [7:0] d, input logic r, input int exp);
    logic [31:0] on = 32'h0;
    set_duty(d, r);
    repeat (4 * (r ? lbd_pkg::SLOT_FAST_CYC : lbd_pkg::SLOT_SLOW_CYC)) begin
      @(negedge clk_i);
      on += led_on;
    end
    chk("led_on_cycles", exp, on);
    $display("test dim done");
  endtask
  task automatic t_soft;
    int         n[2]  = '{0, 0};
    logic       p_pwr = 1'b0;
    logic [1:0] p_sel = 2'h0;
    set_duty(8'hff, 1'b1);
    while (lim_sel !== 2'h2) begin
      @(negedge clk_i);
      if (pwr_on && !p_pwr && p_sel < 2'h2) n[p_sel]++;
      p_pwr = pwr_on;
      p_sel = lim_sel;
    end
    chk("ss1_events", 256, n[0]);
    chk("ss2_events", 256, n[1]);
    $display("test soft done");
  endtask
  task automatic t_maxon;
    logic [31:0] n = 32'h0;
    slow = 1'b1;
    set_duty(8'hff, 1'b1);
    @(posedge pwr_on);
    do begin
      @(negedge clk_i);
      n += pwr_on;
    end while (pwr_on === 1'b1);
    chk("max_on", lbd_pkg::MAX_ON_CYC, n);
    slow = 1'b0;
    $display("test maxon done");
  endtask
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      set_duty(8'hff, 1'b1);
      if (i == 2) duty = 8'h00;
      else {hot, uvlo} = 2'b01 << i;
      repeat (6) @(negedge clk_i);
      chk("off_outputs", 0, {enabled, led_on, pwr_on, lim_sel});
      {hot, uvlo} = 2'b00;
    end
    $display("test fault done");
  endtask
  task automatic complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    // Tests need about 46k cycles; stop well inside the cycle budget
    #900_000;
    err_count++;
    complete_run;
  end
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_dim(8'h80, 1'b1, lbd_pkg::SLOT_FAST_CYC / 2 * 4);
    t_dim(8'h80, 1'b0, lbd_pkg::SLOT_SLOW_CYC / 2 * 4);
    t_dim(8'hc0, 1'b1, lbd_pkg::SLOT_FAST_CYC * 3);
    t_dim(8'h40, 1'b1, lbd_pkg::SLOT_FAST_CYC / 2 * 2);
    t_soft;
    t_maxon;
    t_fault;
    complete_run;
  end
endmodule
